// [wcd_watchdog.sv]
// Watchdog timer steered by the decoded configuration word, with a small register port.
// It assumes the configuration word is stable from reset release and software uses one-cycle strobes.
`timescale 1ns/100ps

// Contract
// RULE1 - Window-size bits 25-24: 11=25%, 10=37.5%, 01=50%, 00=75% of period.
// RULE2 - Bit 23 set: watchdog runs from start-up, software cannot stop it.
// RULE3 - Bit 23 clear: watchdog stopped after start-up, software may start it.
// RULE4 - Bit 22 set selects non-window mode; clear selects window mode.
// RULE5 - Postscale bits 20-16 divide by two to the code.
// RULE6 - Postscale codes above 10100 behave as 10100.
// RULE7 - Programmer writes ones into reserved bits 31-26 and bit 21.
// RULE8 - In window mode a clear before the open window causes a watchdog reset.
module wcd_watchdog (
    input  wire logic        clk_i,        // 125 MHz clock.
    input  wire logic        reset_i,      // Synchronous reset, active high.
    input  wire logic [31:0] cfg_word_i,   // Configuration word, stable.
    input  wire logic [7:0]  addr_i,       // Register byte address.
    input  wire logic [31:0] wdata_i,      // Write data.
    input  wire logic        wr_i,         // Write strobe.
    input  wire logic        rd_i,         // Read strobe.
    output logic      [31:0] rdata_o,      // Read data, cycle after rd_i.
    output logic             wdt_reset_o   // Watchdog reset pulse.
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wcd_pkg::wcd_phase_t phase_q;
    logic [31:0]         cfg_q;
    logic                startup;
    logic                window_on;
    logic [3:0]          shut8;
    logic [4:0]          ps_code;
    logic [20:0]         ratio;
    logic [23:0]         open_at;
    logic                live;
    logic                sw_en_q;
    logic                running;
    logic [7:0]          tick_cnt_q;
    logic                tick;
    logic [20:0]         count_q;
    logic                clear_wr;
    logic                early;
    logic                timeout;
    logic                timeout_flag_q;
    logic                early_flag_q;
    logic                flag_wr;

    // ----------------------------------------------------------------
    // Configuration capture
    // ----------------------------------------------------------------
    // The word is caught one edge after reset release, never by the reset itself.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase_q <= wcd_pkg::WCD_LOAD;
            cfg_q   <= 32'h00000000;
        end
        else
        begin
            case (phase_q)
                wcd_pkg::WCD_LOAD:
                begin
                    cfg_q   <= cfg_word_i; // RULE7
                    phase_q <= wcd_pkg::WCD_LIVE;
                end
                wcd_pkg::WCD_LIVE: phase_q <= wcd_pkg::WCD_LIVE;
                default:           phase_q <= wcd_pkg::WCD_LOAD;
            endcase
        end
    end

    assign live = (phase_q == wcd_pkg::WCD_LIVE);

    wcd_decode wcd_decode_inst (
        .cfg_i     (cfg_q),
        .startup_o (startup),
        .window_o  (window_on),
        .shut8_o   (shut8),
        .ps_code_o (ps_code),
        .ratio_o   (ratio)
    );

    // ----------------------------------------------------------------
    // Enable control
    // ----------------------------------------------------------------
    // Software enable is kept, but a start-up lock overrides any disable.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sw_en_q <= 1'b0;
        end
        else if (wr_i && addr_i == wcd_pkg::OFS_CTRL)
        begin
            sw_en_q <= wdata_i[wcd_pkg::CTRL_SWEN]; // RULE3
        end
    end

    assign running = live && (startup || sw_en_q); // RULE2 RULE3

    // ----------------------------------------------------------------
    // Base tick divider and period counter
    // ----------------------------------------------------------------
    // The divider free-runs only while the timer runs, so a fresh start gets a full first tick.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !running || tick)
        begin
            tick_cnt_q <= 8'h00;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    assign tick     = running && (tick_cnt_q == wcd_pkg::TICK_LAST);
    assign clear_wr = wr_i && (addr_i == wcd_pkg::OFS_CLEAR) && running;
    // Closed span in ticks; for tiny ratios the fraction truncates, opening slightly early.
    assign open_at  = 24'((24'(ratio) * 24'(shut8)) >> wcd_pkg::EIGHTHS_SH);
    assign early    = clear_wr && window_on && (24'(count_q) < open_at); // RULE8 RULE4
    assign timeout  = tick && (count_q == ratio - 21'h000001); // RULE5

    // Any clear, timeout or stop restarts the period.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !running || clear_wr || timeout)
        begin
            count_q <= 21'h000000;
        end
        else if (tick)
        begin
            count_q <= count_q + 21'h000001;
        end
    end

    // Reset pulse is registered so it is glitch-free toward the reset controller.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            wdt_reset_o <= timeout || early; // RULE8
        end
    end

    // ----------------------------------------------------------------
    // Sticky status flags
    // ----------------------------------------------------------------
    // Write one to clear; a new event in the same cycle wins over the clear.
    assign flag_wr = wr_i && (addr_i == wcd_pkg::OFS_STATUS);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timeout_flag_q <= 1'b0;
            early_flag_q   <= 1'b0;
        end
        else
        begin
            timeout_flag_q <= timeout ||
                              (timeout_flag_q && !(flag_wr && wdata_i[wcd_pkg::ST_TIMEOUT]));
            early_flag_q   <= early ||
                              (early_flag_q && !(flag_wr && wdata_i[wcd_pkg::ST_EARLY]));
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Data stand only in the cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !rd_i)
        begin
            rdata_o <= 32'h00000000;
        end
        else
        begin
            case (addr_i)
                wcd_pkg::OFS_CTRL:   rdata_o <= {31'h00000000, sw_en_q};
                wcd_pkg::OFS_STATUS: rdata_o <= {27'h0000000, early_flag_q, timeout_flag_q,
                                                 startup, window_on, running};
                wcd_pkg::OFS_COUNT:  rdata_o <= {11'h000, count_q};
                wcd_pkg::OFS_CFG:    rdata_o <= cfg_q;
                default:             rdata_o <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_early_clear;
        running && window_on && clear_wr && (24'(count_q) < open_at);
    endsequence

    sequence s_period_end;
        tick && (count_q == ratio - 21'h000001);
    endsequence

    a_window_size_25: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        (cfg_q[wcd_pkg::WINSZ_HI:wcd_pkg::WINSZ_LO] == wcd_pkg::WIN_25) |-> (shut8 == wcd_pkg::SHUT8_25))
        else $error("Window code 11 not decoded as 25 percent.");
    a_window_size_75: assert property (@(posedge clk_i) disable iff (reset_i) // RULE1
        (cfg_q[wcd_pkg::WINSZ_HI:wcd_pkg::WINSZ_LO] == wcd_pkg::WIN_75) |-> (shut8 == wcd_pkg::SHUT8_75))
        else $error("Window code 00 not decoded as 75 percent.");
    a_startup_lock: assert property (@(posedge clk_i) disable iff (reset_i) // RULE2
        (live && startup && wr_i && addr_i == wcd_pkg::OFS_CTRL && !wdata_i[wcd_pkg::CTRL_SWEN]) |=> running [*4])
        else $error("Locked watchdog was stopped by software.");
    a_stopped_start: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        ($rose(live) && !startup && !sw_en_q) |-> !running)
        else $error("Unlocked watchdog runs at start-up.");
    a_sw_start: assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
        (live && !startup && wr_i && addr_i == wcd_pkg::OFS_CTRL && wdata_i[wcd_pkg::CTRL_SWEN]) |=> running)
        else $error("Software could not start the watchdog.");
    a_window_mode: assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
        live |-> (window_on == !cfg_q[wcd_pkg::WIN_OFF_BIT]))
        else $error("Window mode does not follow bit 22.");
    a_postscale_ratio: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        (cfg_q[wcd_pkg::PS_HI:wcd_pkg::PS_LO] <= wcd_pkg::PS_MAX) |->
        (ratio == (21'h000001 << cfg_q[wcd_pkg::PS_HI:wcd_pkg::PS_LO])))
        else $error("Postscale ratio is not two to the code.");
    a_postscale_clamp: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
        (cfg_q[wcd_pkg::PS_HI:wcd_pkg::PS_LO] > wcd_pkg::PS_MAX) |-> (ratio == (21'h000001 << wcd_pkg::PS_MAX)))
        else $error("Unlisted postscale code not clamped.");
    a_early_reset: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
        s_early_clear |=> (wdt_reset_o && early_flag_q))
        else $error("Early clear in window mode gave no reset.");
    a_timeout_reset: assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
        s_period_end |=> (wdt_reset_o && count_q == 21'h000000))
        else $error("Period end gave no watchdog reset.");

endmodule

// [wcd_pkg.sv]
// Package for the watchdog configuration-word decoder and its timer.
// It assumes a single 125 MHz clock and a plain strobe-based register port.
package wcd_pkg;

    // ----------------------------------------------------------------
    // Configuration word field layout
    // ----------------------------------------------------------------
    localparam int unsigned CFG_W         = 32;
    localparam int unsigned WINSZ_HI      = 25;
    localparam int unsigned WINSZ_LO      = 24;
    localparam int unsigned STARTUP_EN    = 23;
    localparam int unsigned WIN_OFF_BIT   = 22;
    localparam int unsigned PS_HI         = 20;
    localparam int unsigned PS_LO         = 16;
    localparam int unsigned PS_W          = 5;
    localparam logic [4:0]  PS_MAX        = 5'h14;

    // Window-size codes, and the fraction of the period that stays closed, in eighths.
    localparam logic [1:0]  WIN_25        = 2'h3;
    localparam logic [1:0]  WIN_37        = 2'h2;
    localparam logic [1:0]  WIN_50        = 2'h1;
    localparam logic [1:0]  WIN_75        = 2'h0;
    localparam logic [3:0]  SHUT8_25      = 4'h6;
    localparam logic [3:0]  SHUT8_37      = 4'h5;
    localparam logic [3:0]  SHUT8_50      = 4'h4;
    localparam logic [3:0]  SHUT8_75      = 4'h2;
    localparam int unsigned EIGHTHS_SH    = 3;

    // ----------------------------------------------------------------
    // Timer sizing and base tick
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W         = 21;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYC - 1);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CLEAR     = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_COUNT     = 8'h0C;
    localparam logic [7:0]  OFS_CFG       = 8'h10;
    localparam int unsigned CTRL_SWEN     = 0;
    localparam int unsigned ST_RUN        = 0;
    localparam int unsigned ST_WIN        = 1;
    localparam int unsigned ST_LOCK       = 2;
    localparam int unsigned ST_TIMEOUT    = 3;
    localparam int unsigned ST_EARLY      = 4;

    // Start-up sequencing states.
    typedef enum logic [1:0] {
        WCD_LOAD = 2'b01,
        WCD_LIVE = 2'b10
    } wcd_phase_t;

endpackage

// [wcd_decode.sv]
// Combinational decode of the watchdog fields of the configuration word.
// It assumes the word is held stable by the caller after start-up.
`timescale 1ns/100ps

module wcd_decode (
    input  wire logic [31:0] cfg_i,       // Latched configuration word.
    output logic             startup_o,   // Watchdog forced on from start-up.
    output logic             window_o,    // Window mode selected.
    output logic [3:0]       shut8_o,     // Closed part of period, eighths.
    output logic [4:0]       ps_code_o,   // Effective postscale code.
    output logic [20:0]      ratio_o      // Ticks per watchdog period.
);

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    // The enable bit is direct; the mode bit is window disable, so it is inverted.
    assign startup_o = cfg_i[wcd_pkg::STARTUP_EN];   // RULE2 RULE3
    assign window_o  = ~cfg_i[wcd_pkg::WIN_OFF_BIT]; // RULE4

    // Window size: the open part is the last fraction, so the closed part is its complement.
    always_comb
    begin
        case (cfg_i[wcd_pkg::WINSZ_HI:wcd_pkg::WINSZ_LO]) // RULE1
            wcd_pkg::WIN_25: shut8_o = wcd_pkg::SHUT8_25;
            wcd_pkg::WIN_37: shut8_o = wcd_pkg::SHUT8_37;
            wcd_pkg::WIN_50: shut8_o = wcd_pkg::SHUT8_50;
            default:         shut8_o = wcd_pkg::SHUT8_75;
        endcase
    end

    // Unlisted postscale codes fold onto the largest one.
    always_comb
    begin
        if (cfg_i[wcd_pkg::PS_HI:wcd_pkg::PS_LO] > wcd_pkg::PS_MAX) // RULE6
        begin
            ps_code_o = wcd_pkg::PS_MAX;
        end
        else
        begin
            ps_code_o = cfg_i[wcd_pkg::PS_HI:wcd_pkg::PS_LO];
        end
    end

    // Division ratio is two to the code.
    assign ratio_o = 21'h000001 << ps_code_o; // RULE5

endmodule

// [wcd_watchdog_test.sv]
// Self-checking bench for the watchdog timer steered by the configuration word.
// Assumes a 125-clock tick, the package register map and a word held stable per reset.
`timescale 1ns/100ps

module wcd_watchdog_test;
    logic        clk_i      = 1'b0;          // Bench clock.
    logic        reset_i    = 1'b1;          // Synchronous reset.
    logic [31:0] cfg_word_i = 32'hFFFF_FFFF; // Configuration word.
    logic [7:0]  addr_i     = 8'h00;         // Register address.
    logic [31:0] wdata_i    = 32'h0000_0000; // Write data.
    logic        wr_i       = 1'b0;          // Write strobe.
    logic        rd_i       = 1'b0;          // Read strobe.
    logic [31:0] rdata_o;                    // Read data.
    logic        wdt_reset_o;                // Watchdog reset pulse.
    int          error_cnt  = 0;             // Mismatches.
    int          num_checks = 0;             // Comparisons.
    int          cyc        = 0;             // Clock edges seen.
    int          live_cyc   = 0;             // Edge at which the timer goes live.
    logic        rd_d       = 1'b0;          // Read taken on the previous edge.
    logic [31:0] rd_q[$];                    // Expected read data, oldest first.
    int          pulse_q[$];                 // Exact edge of each expected pulse.

    wcd_watchdog wcd_watchdog_inst (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .cfg_word_i  (cfg_word_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rdata_o     (rdata_o),
        .wdt_reset_o (wdt_reset_o)
    );

    // ----------------------------------------------------------------
    // Clock, compare tasks and closing report
    // ----------------------------------------------------------------
    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("mismatches=%0d comparisons=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Each pulse must show on exactly the edge its scenario predicts, so an off-by-one tick is caught.
    task automatic cmp_pulse(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t pulse edge=%h exp=%h", $time, got, exp);
        end
    endtask

    // Watch the outputs and take the oldest expectation whenever a result appears.
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (rd_d)
            cmp_val(rdata_o, rd_q.pop_front());
        else if (cyc > 0 && rdata_o !== 32'h0)
            cmp_val(rdata_o, 32'h0);
        rd_d <= rd_i;
        if (wdt_reset_o === 1'b1)
            cmp_pulse(cyc, (pulse_q.size() > 0) ? pulse_q.pop_front() : -100);
        if (cyc == 40000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Bus and sequencing tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_q.push_back(exp);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask

    // The word is only captured after a reset, so every new word needs one.
    task automatic apply(input logic [31:0] cfg);
        @(posedge clk_i);
        reset_i    <= 1'b1;
        cfg_word_i <= cfg;
        repeat (12) @(posedge clk_i);
        reset_i    <= 1'b0;
        live_cyc = cyc + 2;
    endtask

    task automatic wait_to(input int t);
        while (cyc < t)
            @(posedge clk_i);
    endtask

    // Any expected pulse still waiting has been missed.
    task automatic drained();
        cmp_val(32'(pulse_q.size()), 32'h0);
        pulse_q.delete();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] c;
        logic [1:0]  w;
        int          s;
        int          n;
        void'($urandom(32'h01644ecf));
        // Random words: captured copy, decoded status and an unmapped place.
        for (int i = 0; i < 6; i++)
        begin
            c = {6'h3F, 2'($urandom), 2'($urandom), 1'b1, 5'($urandom % 21), 16'($urandom)};
            apply(c);
            rd(wcd_pkg::OFS_CFG, c);
            rd(wcd_pkg::OFS_STATUS, {29'h0, c[23], ~c[22], c[23]});
            rd(wcd_pkg::OFS_CTRL, 32'h0);
            wr(8'h20, 32'hFFFF_FFFF);
            rd(8'h20, 32'h0);
        end
        // Locked timer: a software stop is ignored and the period is two to the code.
        for (int k = 0; k < 4; k++)
        begin
            apply({8'hFC, 1'b1, 1'b1, 1'b1, 5'(k), 16'hFFFF});
            wr(wcd_pkg::OFS_CTRL, 32'h0);
            for (int j = 1; j <= 2; j++)
                pulse_q.push_back(live_cyc + 125 * (1 << k) * j);
            wait_to(live_cyc + 250 * (1 << k) + 10);
            drained();
            rd(wcd_pkg::OFS_STATUS, 32'h0000_000D);
        end
        // Unlocked timer stays stopped until software starts it, and may be stopped again.
        apply({8'hFC, 1'b0, 1'b1, 1'b1, 5'h00, 16'hFFFF});
        wait_to(live_cyc + 300);
        drained();
        s = cyc;
        wr(wcd_pkg::OFS_CTRL, 32'h1);
        pulse_q.push_back(s + 128);
        rd(wcd_pkg::OFS_STATUS, 32'h1);
        wait_to(s + 190);
        wr(wcd_pkg::OFS_CTRL, 32'h0);
        wait_to(s + 600);
        drained();
        // Clear one tick inside the closed part, at its edge, and in non-window mode.
        for (int i = 0; i < 12; i++)
        begin
            w = 2'(i % 4);
            n = (w == 2'h0) ? 2 : (w == 2'h1) ? 4 : (w == 2'h2) ? 5 : 6;
            apply({6'h3F, w, 1'b1, (i >= 8), 1'b1, 5'h03, 16'hFFFF});
            if (i < 4)
                n = n - 1;
            if (i >= 8)
                n = 1;
            wait_to(live_cyc + 125 * n + 60);
            if (i < 4)
                pulse_q.push_back(cyc + 3);
            wr(wcd_pkg::OFS_CLEAR, 32'h0);
            // An early clear must leave its sticky flag, and a write of one must clear it.
            if (i < 4)
            begin
                rd(wcd_pkg::OFS_STATUS, 32'h0000_0017);
                wr(wcd_pkg::OFS_STATUS, 32'h0000_0010);
                rd(wcd_pkg::OFS_STATUS, 32'h0000_0007);
            end
            wait_to(cyc + 20);
            drained();
        end
        // Codes above the table act as the largest one: long period, wide closed part.
        for (int i = 0; i < 2; i++)
        begin
            c = {8'hFF, 1'b1, 1'b0, 1'b1, (i == 0) ? 5'h15 : 5'h1F, 16'hFFFF};
            apply(c);
            wait_to(live_cyc + 125 * 30 + 60);
            rd(wcd_pkg::OFS_COUNT, 32'h0000_001E);
            s = cyc;
            pulse_q.push_back(s + 3);
            wr(wcd_pkg::OFS_CLEAR, 32'h0);
            wait_to(s + 20);
            drained();
        end
        end_sim();
    end
endmodule
